/* File: common/fc_pkg.sv */
package fc_pkg;
  localparam logic [7:0] MODE_OFFSET = 8'h60;
  localparam logic [7:0] CMD_OFFSET = 8'h64;
  localparam logic [7:0] STATUS_OFFSET = 8'h68;
  localparam int MODE_RDY_IE_BIT = 0;
  localparam int MODE_LOCK_VIOLATION_FLAG_IE_BIT = 2;
  localparam int MODE_BAD_COMMAND_FLAG_IE_BIT = 3;
  localparam int MODE_NO_ERASE_BEFORE_PROGRAM_BIT = 7;
  localparam int MODE_FWS_LSB = 8;
  localparam int MODE_FMCN_LSB = 16;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_LOCK_VIOLATION_FLAG_BIT = 2;
  localparam int STAT_BAD_COMMAND_FLAG_BIT = 3;
  localparam int STAT_SECURE_BIT = 4;
  localparam int STAT_NVM_LSB = 8;
  localparam int STAT_LOCK_LSB = 16;
  localparam int KEY_LSB = 24;
  localparam int PAGE_LSB = 8;
  localparam int CODE_LSB = 0;
  localparam logic [7:0] CMD_KEY = 8'h5a;
  localparam int PAGE_W = 10;
  localparam int WORD_W = 6;
  localparam int REGION_LSB = 6;
  localparam int REGION_W = 4;
  localparam int LOCK_N = 16;
  localparam int NVM_N = 3;
  localparam logic [PAGE_W-1:0] NVM_COUNT = 10'h003;
  localparam logic [WORD_W-1:0] LAST_WORD = 6'h3f;
  localparam int LATCH_WORDS = 64;
  localparam int LATCH_ADDR_W = 20;
  localparam int LATCH_WORD_LSB = 2;
  localparam logic [3:0] NO_CMD = 4'h0;
  localparam logic [3:0] PAGE_WRITE_CMD = 4'h1;
  localparam logic [3:0] SET_REGION_LOCK_CMD = 4'h2;
  localparam logic [3:0] PAGE_WRITE_LOCK_CMD = 4'h3;
  localparam logic [3:0] CLEAR_REGION_LOCK_CMD = 4'h4;
  localparam logic [3:0] ERASE_WHOLE_CMD = 4'h8;
  localparam logic [3:0] SET_NV_OPTION_CMD = 4'hb;
  localparam logic [3:0] CLEAR_NV_OPTION_CMD = 4'hd;
  localparam logic [3:0] SET_SECURE_CMD = 4'hf;
  localparam logic [LOCK_N-1:0] LOCK_CELL_RESET = 16'hffff;
  localparam logic [NVM_N-1:0] NVM_CELL_RESET = 3'h7;
  localparam logic [1:0] NV_GROUP_LOCK = 2'h0;
  localparam logic [1:0] NV_GROUP_NVM = 2'h1;
  localparam logic [1:0] NV_GROUP_SECURE = 2'h2;
  typedef enum logic [1:0] {
    OP_ERASE_PAGE = 2'b00,
    OP_PROGRAM_WORD = 2'b01,
    OP_ERASE_PLANE = 2'b10,
    OP_NV_WRITE = 2'b11
  } flash_op_type;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ERASE = 3'b001,
    SEQ_PROGRAM = 3'b010,
    SEQ_NV = 3'b011,
    SEQ_ERASE_ALL = 3'b100
  } seq_state_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_type;
  typedef struct packed {
    logic wr;
    logic [LATCH_ADDR_W-1:0] addr;
    logic [31:0] data;
  } latch_wr_type;
  typedef struct packed {
    logic go;
    flash_op_type op;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] word;
    logic [31:0] data;
    logic [7:0] cycles;
  } flash_req_type;
  typedef struct packed {
    logic [7:0] fmcn;
    logic [1:0] fws;
    logic no_erase_before_program;
    logic bad_command_flag_ie;
    logic lock_violation_flag_ie;
    logic rdy_ie;
  } mode_type;
endpackage

/* File: hdl/sync_two_flop.sv */
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage1;
  } sync_state_type;
  sync_state_type s_reg, s_next;
  always_comb begin
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign sync_out = s_reg.stage2;
endmodule

/* File: hdl/flash_command_sequencer.sv */
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - With no-erase clear, the page is erased before it is programmed.
// - With no-erase set, the page is programmed directly, allowing partial writes.
// - Program-and-lock sets the region lock after programming finishes.
// - One-page latch, indexed by low address bits, repeats over the area.
// - Accepted command clears ready from the cycle after it is written.
// - Command completion sets ready and raises irq if enabled.
// - Wrong key or unknown code sets bad-command flag, no operation.
// - Program aimed at a locked region sets lock-violation, page untouched.
// - Erase-whole refused with lock-violation when any region is locked.
// - Lock-violation with its enable set raises irq.
// - Each lock bit guards a region of consecutive pages.
// - Set and clear lock act on the region holding the given page.
// - Unlock stores 1 and reads 0; lock stores 0 and reads 1.
// - Flash reads stay allowed during lock and option-bit commands.
// - Option bits set or cleared singly, index from the page field.
// - Option command with out-of-range index does nothing.
// - Clear option stores 1 and reads 0; set stores 0 and reads 1.
// - Security clears by reset or by erase pin, after plane and bits are erased.
// - Active security blocks external debug and test access.
// - Codes: 1,2,3,4,8,b,d,f decode to the eight commands.
// - Status read clears bad-command and lock-violation flags.
module flash_command_sequencer (
  input wire logic clk,
  input wire logic rst,
  input fc_pkg::bus_req_type bus,
  output logic [31:0] rdata,
  input fc_pkg::latch_wr_type latch,
  output fc_pkg::flash_req_type flash_req,
  input wire logic flash_done,
  input wire logic erase_pin,
  output logic irq,
  output logic read_ok,
  output logic secure_lockout
);
  typedef struct packed {
    fc_pkg::seq_state_type st;
    fc_pkg::mode_type mode;
    logic ready;
    logic lock_violation_flag;
    logic bad_command_flag;
    logic lock_after;
    logic hw_erase;
    logic erase_seen;
    logic erase_pending;
    logic [fc_pkg::LOCK_N-1:0] lock_cell;
    logic [fc_pkg::NVM_N-1:0] nvm_cell;
    logic secure;
    fc_pkg::flash_req_type req;
    logic [31:0] rdata;
    logic irq;
    logic read_ok;
  } state_type;

  state_type s_reg, s_next;
  logic [31:0] latch_mem [fc_pkg::LATCH_WORDS];
  logic erase_sync;
  logic cmd_take, key_ok, page_locked, any_locked, finish;
  logic [3:0] cmd_code;
  logic [fc_pkg::PAGE_W-1:0] cmd_page;
  logic [fc_pkg::REGION_W-1:0] cmd_region;
  logic [fc_pkg::WORD_W-1:0] next_word;
  logic [31:0] mode_word, status_word;

  function automatic fc_pkg::flash_req_type make_req(
    input fc_pkg::flash_op_type op,
    input logic [fc_pkg::PAGE_W-1:0] page,
    input logic [31:0] data,
    input logic [7:0] cycles
  );
    fc_pkg::flash_req_type r;
    r.go = 1'b1;
    r.op = op;
    r.page = page;
    r.word = '0;
    r.data = data;
    r.cycles = cycles;
    return r;
  endfunction

  sync_two_flop #(.WIDTH(1)) erase_sync_inst (
    .clk(clk),
    .rst(rst),
    .async_in(erase_pin),
    .sync_out(erase_sync)
  );

  // No reset on the latch: contents are only meaningful once software fills them
  always_ff @(posedge clk) begin
    if (latch.wr) begin
      latch_mem[latch.addr[fc_pkg::LATCH_WORD_LSB +: fc_pkg::WORD_W]] <= latch.data;
    end
  end

  // Busy sequencer ignores command writes rather than queueing them
  assign cmd_take = bus.wr && (bus.addr == fc_pkg::CMD_OFFSET) &&
                    (s_reg.st == fc_pkg::SEQ_IDLE) && !s_reg.erase_pending;
  assign key_ok = bus.wdata[fc_pkg::KEY_LSB +: 8] == fc_pkg::CMD_KEY;
  assign cmd_code = bus.wdata[fc_pkg::CODE_LSB +: 4];
  assign cmd_page = bus.wdata[fc_pkg::PAGE_LSB +: fc_pkg::PAGE_W];
  assign cmd_region = cmd_page[fc_pkg::REGION_LSB +: fc_pkg::REGION_W];
  assign page_locked = !s_reg.lock_cell[cmd_region];
  assign any_locked = !(&s_reg.lock_cell);
  assign next_word = s_reg.req.word + 6'h01;

  always_comb begin
    mode_word = '0;
    mode_word[fc_pkg::MODE_RDY_IE_BIT] = s_reg.mode.rdy_ie;
    mode_word[fc_pkg::MODE_LOCK_VIOLATION_FLAG_IE_BIT] = s_reg.mode.lock_violation_flag_ie;
    mode_word[fc_pkg::MODE_BAD_COMMAND_FLAG_IE_BIT] = s_reg.mode.bad_command_flag_ie;
    mode_word[fc_pkg::MODE_NO_ERASE_BEFORE_PROGRAM_BIT] = s_reg.mode.no_erase_before_program;
    mode_word[fc_pkg::MODE_FWS_LSB +: 2] = s_reg.mode.fws;
    mode_word[fc_pkg::MODE_FMCN_LSB +: 8] = s_reg.mode.fmcn;
    status_word = '0;
    status_word[fc_pkg::STAT_READY_BIT] = s_reg.ready;
    status_word[fc_pkg::STAT_LOCK_VIOLATION_FLAG_BIT] = s_reg.lock_violation_flag;
    status_word[fc_pkg::STAT_BAD_COMMAND_FLAG_BIT] = s_reg.bad_command_flag;
    status_word[fc_pkg::STAT_SECURE_BIT] = s_reg.secure;
    status_word[fc_pkg::STAT_NVM_LSB +: fc_pkg::NVM_N] = ~s_reg.nvm_cell;
    status_word[fc_pkg::STAT_LOCK_LSB +: fc_pkg::LOCK_N] = ~s_reg.lock_cell;
  end

  always_comb begin
    s_next = s_reg;
    finish = 1'b0;
    s_next.rdata = '0;
    s_next.erase_seen = erase_sync;
    if (bus.rd) begin
      if (bus.addr == fc_pkg::MODE_OFFSET) begin
        s_next.rdata = mode_word;
      end else if (bus.addr == fc_pkg::STATUS_OFFSET) begin
        s_next.rdata = status_word;
        // Cleared before the event logic below, so a same-cycle error survives
        s_next.lock_violation_flag = 1'b0;
        s_next.bad_command_flag = 1'b0;
      end
    end
    if (bus.wr && (bus.addr == fc_pkg::MODE_OFFSET)) begin
      s_next.mode.rdy_ie = bus.wdata[fc_pkg::MODE_RDY_IE_BIT];
      s_next.mode.lock_violation_flag_ie = bus.wdata[fc_pkg::MODE_LOCK_VIOLATION_FLAG_IE_BIT];
      s_next.mode.bad_command_flag_ie = bus.wdata[fc_pkg::MODE_BAD_COMMAND_FLAG_IE_BIT];
      s_next.mode.no_erase_before_program = bus.wdata[fc_pkg::MODE_NO_ERASE_BEFORE_PROGRAM_BIT];
      s_next.mode.fws = bus.wdata[fc_pkg::MODE_FWS_LSB +: 2];
      s_next.mode.fmcn = bus.wdata[fc_pkg::MODE_FMCN_LSB +: 8];
    end
    if ((s_reg.st == fc_pkg::SEQ_IDLE) && s_reg.erase_pending) begin
      // Pin erase ignores locks and wins over any command in this cycle
      s_next.erase_pending = 1'b0;
      s_next.hw_erase = 1'b1;
      s_next.ready = 1'b0;
      s_next.st = fc_pkg::SEQ_ERASE_ALL;
      s_next.req = make_req(fc_pkg::OP_ERASE_PLANE, '0, '0, s_reg.mode.fmcn);
    end else if (cmd_take) begin
      if (!key_ok) begin
        s_next.bad_command_flag = 1'b1;
      end else begin
        unique case (cmd_code)
          fc_pkg::NO_CMD: begin
          end
          fc_pkg::PAGE_WRITE_CMD, fc_pkg::PAGE_WRITE_LOCK_CMD: begin
            if (page_locked) begin
              s_next.lock_violation_flag = 1'b1;
            end else begin
              s_next.ready = 1'b0;
              s_next.lock_after = (cmd_code == fc_pkg::PAGE_WRITE_LOCK_CMD);
              if (s_reg.mode.no_erase_before_program) begin
                s_next.st = fc_pkg::SEQ_PROGRAM;
                s_next.req = make_req(fc_pkg::OP_PROGRAM_WORD, cmd_page, latch_mem[0],
                                      s_reg.mode.fmcn);
              end else begin
                s_next.st = fc_pkg::SEQ_ERASE;
                s_next.req = make_req(fc_pkg::OP_ERASE_PAGE, cmd_page, '0, s_reg.mode.fmcn);
              end
            end
          end
          fc_pkg::SET_REGION_LOCK_CMD, fc_pkg::CLEAR_REGION_LOCK_CMD: begin
            s_next.ready = 1'b0;
            s_next.st = fc_pkg::SEQ_NV;
            s_next.req = make_req(fc_pkg::OP_NV_WRITE,
              {fc_pkg::NV_GROUP_LOCK, 4'h0, cmd_region},
              {31'h0, cmd_code == fc_pkg::CLEAR_REGION_LOCK_CMD}, s_reg.mode.fmcn);
          end
          fc_pkg::ERASE_WHOLE_CMD: begin
            if (any_locked) begin
              s_next.lock_violation_flag = 1'b1;
            end else begin
              s_next.ready = 1'b0;
              s_next.st = fc_pkg::SEQ_ERASE_ALL;
              s_next.req = make_req(fc_pkg::OP_ERASE_PLANE, '0, '0, s_reg.mode.fmcn);
            end
          end
          fc_pkg::SET_NV_OPTION_CMD, fc_pkg::CLEAR_NV_OPTION_CMD: begin
            if (cmd_page < fc_pkg::NVM_COUNT) begin
              s_next.ready = 1'b0;
              s_next.st = fc_pkg::SEQ_NV;
              s_next.req = make_req(fc_pkg::OP_NV_WRITE,
                {fc_pkg::NV_GROUP_NVM, 4'h0, cmd_page[3:0]},
                {31'h0, cmd_code == fc_pkg::CLEAR_NV_OPTION_CMD}, s_reg.mode.fmcn);
            end
          end
          fc_pkg::SET_SECURE_CMD: begin
            s_next.ready = 1'b0;
            s_next.st = fc_pkg::SEQ_NV;
            s_next.req = make_req(fc_pkg::OP_NV_WRITE, {fc_pkg::NV_GROUP_SECURE, 8'h00}, '0,
                                  s_reg.mode.fmcn);
          end
          default: begin
            s_next.bad_command_flag = 1'b1;
          end
        endcase
      end
    end else if ((s_reg.st != fc_pkg::SEQ_IDLE) && flash_done) begin
      unique case (s_reg.st)
        fc_pkg::SEQ_ERASE: begin
          s_next.st = fc_pkg::SEQ_PROGRAM;
          s_next.req.op = fc_pkg::OP_PROGRAM_WORD;
          s_next.req.word = '0;
          s_next.req.data = latch_mem[0];
        end
        fc_pkg::SEQ_PROGRAM: begin
          if (s_reg.req.word != fc_pkg::LAST_WORD) begin
            s_next.req.word = next_word;
            s_next.req.data = latch_mem[next_word];
          end else if (s_reg.lock_after) begin
            s_next.lock_after = 1'b0;
            s_next.st = fc_pkg::SEQ_NV;
            s_next.req = make_req(fc_pkg::OP_NV_WRITE, {fc_pkg::NV_GROUP_LOCK, 4'h0,
              s_reg.req.page[fc_pkg::REGION_LSB +: fc_pkg::REGION_W]}, '0, s_reg.mode.fmcn);
          end else begin
            finish = 1'b1;
          end
        end
        fc_pkg::SEQ_NV: begin
          finish = 1'b1;
          if (s_reg.req.page[9:8] == fc_pkg::NV_GROUP_LOCK) begin
            s_next.lock_cell[s_reg.req.page[3:0]] = s_reg.req.data[0];
          end else if (s_reg.req.page[9:8] == fc_pkg::NV_GROUP_NVM) begin
            s_next.nvm_cell[s_reg.req.page[1:0]] = s_reg.req.data[0];
          end else begin
            s_next.secure = 1'b1;
          end
        end
        fc_pkg::SEQ_ERASE_ALL: begin
          finish = 1'b1;
          if (s_reg.hw_erase) begin
            s_next.hw_erase = 1'b0;
            s_next.lock_cell = fc_pkg::LOCK_CELL_RESET;
            s_next.nvm_cell = fc_pkg::NVM_CELL_RESET;
            s_next.secure = 1'b0;
          end
        end
        default: begin
          finish = 1'b1;
        end
      endcase
    end
    if (finish) begin
      s_next.st = fc_pkg::SEQ_IDLE;
      s_next.ready = 1'b1;
      s_next.req.go = 1'b0;
    end
    if (erase_sync && !s_reg.erase_seen) begin
      s_next.erase_pending = 1'b1;
    end
    s_next.irq = (s_next.ready & s_next.mode.rdy_ie) |
                 (s_next.lock_violation_flag & s_next.mode.lock_violation_flag_ie) |
                 (s_next.bad_command_flag & s_next.mode.bad_command_flag_ie);
    // Only page erase, plane erase and page programming take the array away from reads
    s_next.read_ok = !((s_next.st == fc_pkg::SEQ_ERASE) ||
                       (s_next.st == fc_pkg::SEQ_PROGRAM) ||
                       (s_next.st == fc_pkg::SEQ_ERASE_ALL));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ready <= 1'b1;
      s_reg.read_ok <= 1'b1;
      s_reg.lock_cell <= fc_pkg::LOCK_CELL_RESET;
      s_reg.nvm_cell <= fc_pkg::NVM_CELL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign flash_req = s_reg.req;
  assign irq = s_reg.irq;
  assign read_ok = s_reg.read_ok;
  assign secure_lockout = s_reg.secure;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_cmd_clears_ready: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::PAGE_WRITE_CMD) && !page_locked
    |=> !s_reg.ready && (s_reg.st != fc_pkg::SEQ_IDLE) && s_reg.req.go)
    else $error("ready not cleared by accepted page command");
  a_auto_erase_first: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::PAGE_WRITE_CMD) && !page_locked &&
    !s_reg.mode.no_erase_before_program |=> (s_reg.st == fc_pkg::SEQ_ERASE) &&
    (s_reg.req.op == fc_pkg::OP_ERASE_PAGE) && (s_reg.req.page == $past(cmd_page)))
    else $error("page not erased before programming");
  a_no_erase_mode: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::PAGE_WRITE_CMD) && !page_locked &&
    s_reg.mode.no_erase_before_program |=> (s_reg.st == fc_pkg::SEQ_PROGRAM) && (s_reg.req.word == '0))
    else $error("erase issued while no-erase is set");
  a_bad_key_flag: assert property (
    cmd_take && !key_ok |=> s_reg.bad_command_flag && (s_reg.st == fc_pkg::SEQ_IDLE))
    else $error("bad key did not raise bad-command flag");
  a_locked_page_refused: assert property (
    cmd_take && key_ok && page_locked && ((cmd_code == fc_pkg::PAGE_WRITE_CMD) ||
    (cmd_code == fc_pkg::PAGE_WRITE_LOCK_CMD)) |=> s_reg.lock_violation_flag &&
    (s_reg.st == fc_pkg::SEQ_IDLE) && s_reg.ready)
    else $error("locked page was not refused");
  a_erase_all_refused: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::ERASE_WHOLE_CMD) && any_locked
    |=> s_reg.lock_violation_flag && (s_reg.st == fc_pkg::SEQ_IDLE))
    else $error("erase-whole ran with a locked region");
  a_finish_sets_ready: assert property (
    (s_reg.st != fc_pkg::SEQ_IDLE) && (s_next.st == fc_pkg::SEQ_IDLE)
    |=> s_reg.ready && (s_reg.irq || !s_reg.mode.rdy_ie))
    else $error("completion did not set ready and irq");
  a_lock_error_irq: assert property (
    s_reg.lock_violation_flag && s_reg.mode.lock_violation_flag_ie |-> s_reg.irq)
    else $error("lock violation did not raise irq");
  a_status_read_clears: assert property (
    bus.rd && (bus.addr == fc_pkg::STATUS_OFFSET) && !bus.wr
    |=> !s_reg.bad_command_flag && !s_reg.lock_violation_flag)
    else $error("status read left error flags set");
  a_wpl_then_lock: assert property (
    (s_reg.st == fc_pkg::SEQ_PROGRAM) && flash_done && s_reg.lock_after &&
    (s_reg.req.word == fc_pkg::LAST_WORD) |=> (s_reg.st == fc_pkg::SEQ_NV) &&
    (s_reg.req.op == fc_pkg::OP_NV_WRITE) && !s_reg.req.data[0] &&
    (s_reg.req.page[9:8] == fc_pkg::NV_GROUP_LOCK) &&
    (s_reg.req.page[3:0] == $past(s_reg.req.page[fc_pkg::REGION_LSB +: fc_pkg::REGION_W])))
    else $error("program-and-lock did not lock its region");
  a_unlock_stores_one: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::CLEAR_REGION_LOCK_CMD)
    |=> s_reg.req.data[0] && (s_reg.req.page[3:0] == $past(cmd_region)))
    else $error("unlock does not program the cell to one");
  a_read_during_nv: assert property (
    (s_reg.st == fc_pkg::SEQ_NV) |-> s_reg.read_ok)
    else $error("reads blocked during option-bit command");
  a_nv_index_range: assert property (
    cmd_take && key_ok && (cmd_code == fc_pkg::SET_NV_OPTION_CMD) &&
    (cmd_page >= fc_pkg::NVM_COUNT) |=> (s_reg.st == fc_pkg::SEQ_IDLE) &&
    (s_reg.nvm_cell == $past(s_reg.nvm_cell)))
    else $error("out-of-range option index had an effect");
  a_secure_sticky: assert property (
    s_reg.secure && !(s_reg.hw_erase && flash_done) |=> s_reg.secure)
    else $error("security cleared without pin erase");

  c_page_done: cover property (
    (s_reg.st == fc_pkg::SEQ_PROGRAM) && flash_done && (s_reg.req.word == fc_pkg::LAST_WORD));
  c_erase_whole: cover property (
    (s_reg.st == fc_pkg::SEQ_ERASE_ALL) && !s_reg.hw_erase && flash_done);
  c_nv_done: cover property ((s_reg.st == fc_pkg::SEQ_NV) && flash_done);
  c_pin_erase: cover property (s_reg.hw_erase && flash_done && s_reg.secure);
endmodule

/* File: tb/flash_macro_model.sv */
`timescale 1ns/1ps
module flash_macro_model (
  input wire logic clk,
  input wire logic rst,
  input fc_pkg::flash_req_type req,
  output logic done,
  output logic [15:0] n_op [4],
  output logic [31:0] prog_mem [64]
);
  logic [2:0] wait_reg;
  // Random latency so both prompt and slow completions occur
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      wait_reg <= 3'h0;
      n_op <= '{default: 16'h0};
    end else begin
      done <= 1'b0;
      if (wait_reg != 3'h0) begin
        wait_reg <= wait_reg - 3'h1;
        if (wait_reg == 3'h1) begin
          done <= 1'b1;
          n_op[req.op] <= n_op[req.op] + 16'h1;
          if (req.op == fc_pkg::OP_PROGRAM_WORD) begin
            prog_mem[req.word] <= req.data;
          end
        end
      end else if (req.go && !done) begin
        // Fields change the cycle after done, so skip that cycle
        wait_reg <= 3'($urandom_range(1, 5));
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module testbench;
  logic clk, rst, flash_done, erase_pin, irq, read_ok, secure_lockout, sec;
  logic rd_seen = 1'b0;
  fc_pkg::bus_req_type bus;
  fc_pkg::latch_wr_type latch;
  fc_pkg::flash_req_type flash_req;
  logic [31:0] rdata, mode, e_now;
  logic [31:0] exp_mem [64];
  logic [31:0] prog_mem [64];
  logic [15:0] n_op [4];
  logic [15:0] lock_st;
  logic [2:0] opt_st;
  logic [31:0] exp_q [$];
  logic [21:0] tbl [16];
  int fails, cmp_count, n;

  flash_command_sequencer i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .latch(latch), .flash_req(flash_req), .flash_done(flash_done), .erase_pin(erase_pin),
    .irq(irq), .read_ok(read_ok), .secure_lockout(secure_lockout));
  flash_macro_model i_flash (.clk(clk), .rst(rst), .req(flash_req), .done(flash_done),
    .n_op(n_op), .prog_mem(prog_mem));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read data is valid only in the cycle after the read strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      e_now = exp_q.pop_front();
      `CHK("rdata", e_now, rdata)
    end
    rd_seen <= bus.rd;
  end

  function automatic logic [31:0] st(input logic pe, input logic lk);
    return {lock_st, 5'h00, opt_st, 3'h0, sec, pe, lk, 1'b0, 1'b1};
  endfunction

  task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_op(1'b0, a, 32'h0);
  endtask

  task automatic fill();
    for (int i = 0; i < 64; i++) begin
      exp_mem[i] = $urandom;
      // Random upper address bits: the latch repeats over the area
      latch <= '{wr: 1'b1, addr: {12'($urandom), 6'(i), 2'b00}, data: exp_mem[i]};
      @(posedge clk);
      latch <= '0;
      @(posedge clk);
    end
  endtask

  task automatic wait_idle();
    n = 0;
    while (flash_req.go === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n == 5000) fails++;
  endtask

  task automatic do_cmd(input logic [7:0] key, input logic [3:0] code, input logic [9:0] pg);
    logic pe, lk, ge;
    pe = key !== fc_pkg::CMD_KEY ||
      !(code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hd, 4'hf});
    lk = !pe && ((code inside {4'h1, 4'h3} && lock_st[pg[9:6]]) || (code == 4'h8 && |lock_st));
    ge = !pe && !lk && code != 4'h0 && !(code inside {4'hb, 4'hd} && pg >= 10'h003);
    bus_op(1'b1, fc_pkg::CMD_OFFSET, {key, 6'h00, pg, 4'h0, code});
    #1;
    `CHK("go", ge, flash_req.go)
    if (ge) `CHK("read_ok", !(code inside {4'h1, 4'h3, 4'h8}), read_ok)
    if (ge) `CHK("cycles", mode[23:16], flash_req.cycles)
    if (ge && code inside {4'h1, 4'h3}) `CHK("page", pg, flash_req.page)
    if (ge && code inside {4'h2, 4'h4})
      `CHK("region", {6'h00, pg[9:6]}, flash_req.page)
    if (ge && code inside {4'h2, 4'h4, 4'hb, 4'hd})
      `CHK("cell", code inside {4'h4, 4'hd}, flash_req.data[0])
    wait_idle();
    @(posedge clk);
    #1;
    if (ge) begin
      case (code)
        4'h2, 4'h3: lock_st[pg[9:6]] = 1'b1;
        4'h4: lock_st[pg[9:6]] = 1'b0;
        4'hb: opt_st[pg[1:0]] = 1'b1;
        4'hd: opt_st[pg[1:0]] = 1'b0;
        4'hf: sec = 1'b1;
        default: ;
      endcase
    end
    `CHK("irq", mode[0] | (lk & mode[2]) | (pe & mode[3]), irq)
    @(posedge clk);
    rd(fc_pkg::STATUS_OFFSET, st(pe, lk));
  endtask

  task automatic page_write(input logic [31:0] m);
    mode = m;
    bus_op(1'b1, fc_pkg::MODE_OFFSET, mode);
    fill();
    do_cmd(fc_pkg::CMD_KEY, 4'h1, 10'h2a7);
    for (int i = 0; i < 64; i++) `CHK("prog", exp_mem[i], prog_mem[i])
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    latch = '0;
    erase_pin = 1'b0;
    lock_st = 16'h0;
    opt_st = 3'h0;
    sec = 1'b0;
    mode = 32'h0;
    void'($urandom(32'hd026f6e9));
    tbl = '{{8'h5a, 4'h3, 10'h0c5}, {8'h5a, 4'h1, 10'h0c0}, {8'h5a, 4'h8, 10'h000},
      {8'ha5, 4'h1, 10'h000}, {8'h5a, 4'h5, 10'h000}, {8'h5a, 4'h0, 10'h000},
      {8'h5a, 4'h4, 10'h0ff}, {8'h5a, 4'h2, 10'h3c0}, {8'h5a, 4'hb, 10'h001},
      {8'h5a, 4'hb, 10'h005}, {8'h5a, 4'hd, 10'h001}, {8'h5a, 4'h4, 10'h3ff},
      {8'h5a, 4'h8, 10'h000}, {8'h5a, 4'h2, 10'h040}, {8'h5a, 4'hb, 10'h002},
      {8'h5a, 4'hf, 10'h000}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(fc_pkg::MODE_OFFSET, 32'h0);
    rd(fc_pkg::STATUS_OFFSET, st(1'b0, 1'b0));
    rd(8'h6c, 32'h0);
    page_write(32'h1);
    `CHK("erases", 16'h1, n_op[0])
    page_write(32'h81);
    `CHK("erases", 16'h1, n_op[0])
    `CHK("programs", 16'h80, n_op[1])
    mode = 32'h0037028c;
    bus_op(1'b1, fc_pkg::MODE_OFFSET, mode);
    rd(fc_pkg::MODE_OFFSET, mode);
    // Lock, error, option and security sequence; every command code at least once
    foreach (tbl[i]) do_cmd(tbl[i][21:14], tbl[i][13:10], tbl[i][9:0]);
    `CHK("plane", 16'h1, n_op[2])
    `CHK("lockout", 1'b1, secure_lockout)
    erase_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("pin_op", fc_pkg::OP_ERASE_PLANE, flash_req.op)
    wait_idle();
    erase_pin <= 1'b0;
    repeat (2) @(posedge clk);
    lock_st = 16'h0;
    opt_st = 3'h0;
    sec = 1'b0;
    rd(fc_pkg::STATUS_OFFSET, st(1'b0, 1'b0));
    #1;
    `CHK("lockout", 1'b0, secure_lockout)
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
